// *** logic/sbtc_pkg.sv ***
// package: register map, fields and constants of the 16-bit timer/counter
package sbtc_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL  = 8'h10;
    localparam logic [7:0] ADDR_COUNT_LO = 8'h14;
    localparam logic [7:0] ADDR_COUNT_HI = 8'h18;
    localparam logic [7:0] ADDR_STATUS   = 8'h1C;
    localparam logic [7:0] ADDR_PINDIR   = 8'h20;

    // ------------------------------------------------------------------
    // control and status fields
    // ------------------------------------------------------------------
    localparam int BIT_COUNT_EN  = 0;
    localparam int BIT_CLK_SEL   = 1;
    localparam int BIT_SYNC_DIS  = 2;
    localparam int BIT_OSC_EN    = 3;
    localparam int BIT_PS_LO     = 4;
    localparam int BIT_PS_HI     = 5;
    localparam int BIT_OVF_FLAG  = 0;

    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_MASK  = 8'h3F;
    localparam logic [1:0] PINDIR_RESET  = 2'h3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // prescale ratio to terminal count of a 3-bit divider
    function automatic logic [2:0] sbtc_ps_limit(input logic [1:0] sel);
        case (sel)
            2'h0:    sbtc_ps_limit = 3'h0;
            2'h1:    sbtc_ps_limit = 3'h1;
            2'h2:    sbtc_ps_limit = 3'h3;
            default: sbtc_ps_limit = 3'h7;
        endcase
    endfunction : sbtc_ps_limit

endpackage : sbtc_pkg

// *** logic/sbtc_sync2.sv ***
// two-stage synchroniser for asynchronous levels
`timescale 1ns/100ps
module sbtc_sync2 (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic ce_i,
    // data
    input  wire logic d_i,
    output logic      q_o
);
    typedef struct packed {
        logic s1;
        logic s2;
    } sbtc_sync_t;

    sbtc_sync_t st_reg;
    sbtc_sync_t st_next;

    always_comb begin
        st_next = st_reg;
        if (ce_i) begin
            st_next.s1 = d_i;
            st_next.s2 = st_reg.s1;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q_o = st_reg.s2;
endmodule : sbtc_sync2

// *** logic/sbtc_async_cnt.sv ***
// asynchronous ripple prescaler counted on the external clock pin
`timescale 1ns/100ps
module sbtc_async_cnt
    import sbtc_pkg::*;
(
    // pin clock domain
    input  wire logic       ext_clk_i,
    input  wire logic       rstn_i,
    // control, quasi-static
    input  wire logic       run_i,
    input  wire logic [1:0] ps_sel_i,
    // tick toggles once per prescaled edge
    output logic            tick_tgl_o
);
    typedef struct packed {
        logic [2:0] div;
        logic       tgl;
    } sbtc_acnt_t;

    sbtc_acnt_t st_reg;
    sbtc_acnt_t st_next;

    // counts on rising edges of the pin only; never on falling edges
    always_comb begin
        st_next = st_reg;
        if (run_i) begin
            if (st_reg.div >= sbtc_ps_limit(ps_sel_i)) begin
                st_next.div = 3'h0;
                st_next.tgl = ~st_reg.tgl;
            end else begin
                st_next.div = st_reg.div + 3'h1;
            end
        end
    end

    always_ff @(posedge ext_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick_tgl_o = st_reg.tgl;
endmodule : sbtc_async_cnt

// *** logic/sbtc_top.sv ***
// top: 16-bit timer/counter with AXI4-Lite register slave
// Summary of operation
// - 16-bit count wraps all ones to zero and requests an interrupt
// - control bit 0 starts counting when set, stops when cleared
// - control bit 1 selects internal clock (0) or external pin (1)
// - timer mode advances counter or prescaler every instruction cycle
// - counter mode advances only on rising edges of the external input
// - oscillator enable bit 3 makes both pins inputs, overriding direction
// - oscillator disabled shuts it down; pins follow direction bits again
// - bit 2 zero synchronises external clock, one counts asynchronously
// - internal clock mode ignores the synchronisation bit
// - bits 5:4 select prescale 1:1, 1:2, 1:4 or 1:8
// - special event trigger pulse clears the 16-bit count
// - control bits 7:6 ignore writes and read as zero
`timescale 1ns/100ps
module sbtc_top
    import sbtc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock, reset, enable
    input  wire logic              clk_sys_i,
    input  wire logic              rstn_i,
    input  wire logic              ce_i,
    // instruction cycle strobe
    input  wire logic              instr_cycle_i,
    // special event trigger from the capture/compare unit
    input  wire logic              cc_trigger_i,
    // external clock pin
    input  wire logic              ext_clock_pin_i,
    // oscillator pins
    input  wire logic [1:0]        port_out_i,
    output logic [1:0]             osc_pin_o,
    output logic [1:0]             osc_pin_oe_o,
    output logic                   osc_run_o,
    // interrupt request
    output logic                   overflow_irq_o,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // axi4-lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]        control;
        logic [15:0]       count;
        logic [2:0]        div;
        logic              ovf_flag;
        logic              irq;
        logic [1:0]        pindir;
        logic              ext_prev;
        logic              tgl_prev;
        logic              aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_held;
        logic [31:0]       w_data;
        logic [3:0]        w_strb;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [1:0]        pin_o;
        logic [1:0]        pin_oe;
    } sbtc_state_t;

    sbtc_state_t st_reg;
    sbtc_state_t st_next;

    localparam sbtc_state_t ST_RESET = '{
        control: CONTROL_RESET, pindir: PINDIR_RESET,
        awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};

    logic [1:0] rst_sh_reg;
    logic rstn_sync;
    logic ext_sync;
    logic tgl_sync;
    logic async_tgl;
    logic async_run;

    // ------------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sh_reg <= 2'h0;
        end else begin
            rst_sh_reg <= {rst_sh_reg[0], 1'b1};
        end
    end
    assign rstn_sync = rst_sh_reg[1];

    sbtc_sync2 u_ext_sync (
        .clk_i  (clk_sys_i),
        .rstn_i (rstn_sync),
        .ce_i   (ce_i),
        .d_i    (ext_clock_pin_i),
        .q_o    (ext_sync)
    );

    // async path runs only when external, unsynchronised, enabled
    assign async_run = st_reg.control[BIT_COUNT_EN]
                     & st_reg.control[BIT_CLK_SEL]
                     & st_reg.control[BIT_SYNC_DIS];

    sbtc_async_cnt u_async (
        .ext_clk_i  (ext_clock_pin_i),
        .rstn_i     (rstn_sync),
        .run_i      (async_run),
        .ps_sel_i   (st_reg.control[BIT_PS_HI:BIT_PS_LO]),
        .tick_tgl_o (async_tgl)
    );

    sbtc_sync2 u_tgl_sync (
        .clk_i  (clk_sys_i),
        .rstn_i (rstn_sync),
        .ce_i   (ce_i),
        .d_i    (async_tgl),
        .q_o    (tgl_sync)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    logic              src_tick;
    logic              cnt_tick;
    logic              wr_go;
    logic              wrap;
    logic [ADDR_W-1:0] waddr;
    logic [31:0]       wd;
    logic [ADDR_W-1:0] raddr;

    always_comb begin
        st_next   = st_reg;
        src_tick  = 1'b0;
        cnt_tick  = 1'b0;
        wrap      = 1'b0;
        waddr     = st_reg.aw_held ? st_reg.aw_addr : s_axi_awaddr;
        wd        = st_reg.w_held ? st_reg.w_data : s_axi_wdata;
        raddr     = s_axi_araddr;
        wr_go     = 1'b0;
        if (ce_i) begin
            // clock source selection
            if (!st_reg.control[BIT_CLK_SEL]) begin
                src_tick = instr_cycle_i;
            end else if (!st_reg.control[BIT_SYNC_DIS]) begin
                src_tick = ext_sync & ~st_reg.ext_prev;
            end
            st_next.ext_prev = ext_sync;
            st_next.tgl_prev = tgl_sync;

            // prescaler, then counter
            if (st_reg.control[BIT_COUNT_EN]) begin
                if (async_run) begin
                    cnt_tick = tgl_sync ^ st_reg.tgl_prev;
                end else if (src_tick) begin
                    if (st_reg.div >= sbtc_ps_limit(
                            st_reg.control[BIT_PS_HI:BIT_PS_LO])) begin
                        st_next.div = 3'h0;
                        cnt_tick    = 1'b1;
                    end else begin
                        st_next.div = st_reg.div + 3'h1;
                    end
                end
            end
            if (cnt_tick) begin
                st_next.count = st_reg.count + 16'h0001;
                wrap = (st_reg.count == 16'hFFFF);
            end

            // write channel capture
            if (s_axi_awvalid && st_reg.awready) begin
                st_next.aw_held = 1'b1;
                st_next.aw_addr = s_axi_awaddr;
                st_next.awready = 1'b0;
            end
            if (s_axi_wvalid && st_reg.wready) begin
                st_next.w_held = 1'b1;
                st_next.w_data = s_axi_wdata;
                st_next.w_strb = s_axi_wstrb;
                st_next.wready = 1'b0;
            end
            wr_go = (st_reg.aw_held || (s_axi_awvalid && st_reg.awready))
                 && (st_reg.w_held || (s_axi_wvalid && st_reg.wready))
                 && !st_reg.bvalid;
            if (wr_go) begin
                st_next.aw_held = 1'b0;
                st_next.w_held  = 1'b0;
                st_next.bvalid  = 1'b1;
                st_next.bresp   = RESP_OKAY;
                if ((st_reg.w_held ? st_reg.w_strb[0] : s_axi_wstrb[0])
                        == 1'b0) begin
                    // no low lane: nothing stored
                end else if (waddr == ADDR_CONTROL) begin
                    st_next.control = wd[7:0] & CONTROL_MASK;
                end else if (waddr == ADDR_COUNT_LO) begin
                    st_next.count[7:0] = wd[7:0];
                    wrap = 1'b0;
                end else if (waddr == ADDR_COUNT_HI) begin
                    st_next.count[15:8] = wd[7:0];
                    wrap = 1'b0;
                end else if (waddr == ADDR_STATUS) begin
                    if (wd[BIT_OVF_FLAG]) begin
                        st_next.ovf_flag = 1'b0;
                    end
                end else if (waddr == ADDR_PINDIR) begin
                    st_next.pindir = wd[1:0];
                end else begin
                    st_next.bresp = RESP_SLVERR;
                end
            end
            if (st_reg.bvalid && s_axi_bready) begin
                st_next.bvalid  = 1'b0;
                st_next.awready = 1'b1;
                st_next.wready  = 1'b1;
            end

            // special event trigger clears the count
            if (cc_trigger_i) begin
                st_next.count = 16'h0000;
            end
            // set wins over software clear
            if (wrap) begin
                st_next.ovf_flag = 1'b1;
            end
            st_next.irq = st_next.ovf_flag;

            // read channel
            if (s_axi_arvalid && st_reg.arready) begin
                st_next.arready = 1'b0;
                st_next.rvalid  = 1'b1;
                st_next.rresp   = RESP_OKAY;
                st_next.rdata   = 32'h0000_0000;
                if (raddr == ADDR_CONTROL) begin
                    st_next.rdata[7:0] = st_reg.control & CONTROL_MASK;
                end else if (raddr == ADDR_COUNT_LO) begin
                    st_next.rdata[7:0] = st_reg.count[7:0];
                end else if (raddr == ADDR_COUNT_HI) begin
                    st_next.rdata[7:0] = st_reg.count[15:8];
                end else if (raddr == ADDR_STATUS) begin
                    st_next.rdata[BIT_OVF_FLAG] = st_reg.ovf_flag;
                end else if (raddr == ADDR_PINDIR) begin
                    st_next.rdata[1:0] = st_reg.pindir;
                end else begin
                    st_next.rresp = RESP_SLVERR;
                end
            end
            if (st_reg.rvalid && s_axi_rready) begin
                st_next.rvalid  = 1'b0;
                st_next.arready = 1'b1;
            end

            // oscillator pins: inputs while oscillator on
            if (st_next.control[BIT_OSC_EN]) begin
                st_next.pin_oe = 2'h0;
            end else begin
                st_next.pin_oe = ~st_next.pindir;
            end
            st_next.pin_o = port_out_i;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rstn_sync) begin
        if (!rstn_sync) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign osc_pin_o      = st_reg.pin_o;
    assign osc_pin_oe_o   = st_reg.pin_oe;
    assign osc_run_o      = st_reg.control[BIT_OSC_EN];
    assign overflow_irq_o = st_reg.irq;
    assign s_axi_awready  = st_reg.awready;
    assign s_axi_wready   = st_reg.wready;
    assign s_axi_bresp    = st_reg.bresp;
    assign s_axi_bvalid   = st_reg.bvalid;
    assign s_axi_arready  = st_reg.arready;
    assign s_axi_rdata    = st_reg.rdata;
    assign s_axi_rresp    = st_reg.rresp;
    assign s_axi_rvalid   = st_reg.rvalid;
endmodule : sbtc_top

// *** dv/sbtc_ext_src.sv ***
// external clock source model driving the timer input pin
`timescale 1ns/100ps
module sbtc_ext_src (
    // pin
    output logic pin_o
);
    initial pin_o = 1'b0;

    // ------------------------------------------------------------------
    // bursts of pulses, pin rests low between them
    // ------------------------------------------------------------------
    task automatic burst(input int n, input int half_ns);
        repeat (n) begin
            #(half_ns) pin_o = 1'b1;
            #(half_ns) pin_o = 1'b0;
        end
    endtask : burst
endmodule : sbtc_ext_src

// *** dv/sbtc_top_props.sv ***
// concurrent checks on the ports of the timer/counter top
`timescale 1ns/100ps
module sbtc_top_props
    import sbtc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic              clk_sys_i,
    input wire logic              rstn_i,
    input wire logic              ce_i,
    // pins
    input wire logic [1:0]        osc_pin_oe_o,
    input wire logic              osc_run_o,
    input wire logic              overflow_irq_o,
    // register bus
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready
);
    logic [ADDR_W-1:0] rd_addr_reg;
    logic              st_wr_reg;
    logic              map_w;

    // ------------------------------------------------------------------
    // last read address and last write target
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_addr_reg <= '0;
            st_wr_reg   <= 1'b0;
        end else if (ce_i) begin
            if (s_axi_arvalid && s_axi_arready)
                rd_addr_reg <= s_axi_araddr;
            if (s_axi_awvalid && s_axi_awready)
                st_wr_reg <= (s_axi_awaddr == ADDR_STATUS);
        end
    end
    assign map_w = rd_addr_reg inside {ADDR_CONTROL, ADDR_COUNT_LO,
        ADDR_COUNT_HI, ADDR_STATUS, ADDR_PINDIR};

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_b_after_write: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && ce_i |=> s_axi_bvalid) else $error("no write response");
    a_bvalid_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_write_refused: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_readies_back: assert property (
        s_axi_bvalid && s_axi_bready && ce_i
        |=> s_axi_awready && s_axi_wready && !s_axi_bvalid)
        else $error("write channel not reopened");
    a_r_after_ar: assert property (
        s_axi_arvalid && s_axi_arready && ce_i
        |=> s_axi_rvalid && !s_axi_arready) else $error("no read data");
    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_rresp_code: assert property (
        s_axi_rvalid |-> s_axi_rresp == (map_w ? RESP_OKAY : RESP_SLVERR))
        else $error("wrong read response");
    a_ctrl_top_zero: assert property (
        s_axi_rvalid && rd_addr_reg == ADDR_CONTROL
        |-> s_axi_rdata[7:6] == 2'h0) else $error("control 7:6 not zero");
    a_osc_pins_in: assert property (
        osc_run_o |-> osc_pin_oe_o == 2'h0)
        else $error("pin driven with oscillator on");
    a_irq_clear: assert property (
        $fell(overflow_irq_o) |-> s_axi_bvalid && st_wr_reg)
        else $error("flag cleared without software");

    c_irq: cover property ($rose(overflow_irq_o));
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
    c_osc: cover property (osc_run_o);
endmodule : sbtc_top_props

bind sbtc_top sbtc_top_props #(.ADDR_W(ADDR_W)) i_sbtc_top_props (.*);

// *** dv/tb_top.sv ***
// self-checking bench for the 16-bit timer/counter
`timescale 1ns/100ps
module tb_top
    import sbtc_pkg::*;
;
    logic        clk_sys_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        ce_i = 1'b1;
    logic        instr_cycle_i = 1'b0;
    logic        cc_trigger_i = 1'b0;
    logic        ext_clock_pin_i;
    logic [1:0]  port_out_i = 2'h0;
    logic [1:0]  osc_pin_o, osc_pin_oe_o, s_axi_bresp, s_axi_rresp;
    logic        osc_run_o, overflow_irq_o;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [31:0] s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    int          mismatches = 0;
    int          tests_run = 0;
    int          ps;
    logic [33:0] exp_q[$];
    logic [33:0] got;
    logic [7:0]  seed = 8'h5C;
    logic [7:0]  v1, v2;

    sbtc_top i_sbtc_top (.*);
    sbtc_ext_src i_sbtc_ext_src (.pin_o(ext_clock_pin_i));

    always #12.5 clk_sys_i = ~clk_sys_i;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    task automatic cmp(input logic [33:0] e, input logic [33:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : cmp

    task automatic chk(input logic [1:0] g, input logic [1:0] e);
        cmp({32'h0, e}, {32'h0, g});
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        exp_q.push_back({a inside {ADDR_CONTROL, ADDR_COUNT_LO,
            ADDR_COUNT_HI, ADDR_STATUS, ADDR_PINDIR} ? RESP_OKAY
            : RESP_SLVERR, 32'h0});
        @(posedge clk_sys_i);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 50 && !s_axi_bvalid; n++) begin
            @(posedge clk_sys_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        if (!s_axi_bvalid) begin
            mismatches++;
            report_and_stop();
        end
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [1:0] r,
                      input logic [31:0] d);
        int n;
        exp_q.push_back({r, d});
        @(posedge clk_sys_i);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 50 && !s_axi_rvalid; n++) begin
            @(posedge clk_sys_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        if (!s_axi_rvalid) begin
            mismatches++;
            report_and_stop();
        end
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic ro(input logic [7:0] a, input logic [7:0] d);
        rd(a, RESP_OKAY, {24'h0, d});
    endtask : ro

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_sys_i);
            instr_cycle_i <= 1'b1;
            @(posedge clk_sys_i);
            instr_cycle_i <= 1'b0;
        end
    endtask : tick

    // ------------------------------------------------------------------
    // write and read response monitor, error read data ignored
    // ------------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        if (s_axi_bvalid && s_axi_bready)
            cmp(exp_q.pop_front(), {s_axi_bresp, 32'h0});
        if (s_axi_rvalid && s_axi_rready) begin
            got = {s_axi_rresp, s_axi_rdata};
            if (got[33:32] === RESP_SLVERR) got[31:0] = 32'h0;
            cmp(exp_q.pop_front(), got);
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        cyc(4);
        ro(ADDR_CONTROL, CONTROL_RESET);
        ro(ADDR_PINDIR, {6'h0, PINDIR_RESET});
        ro(ADDR_STATUS, 8'h00);
        rd(8'h30, RESP_SLVERR, 32'h0);
        wr(8'h30, 8'hFF);
        wr(ADDR_CONTROL, 8'hFF);
        ro(ADDR_CONTROL, CONTROL_MASK);
        wr(ADDR_CONTROL, 8'h00);
        seed = lfsr(seed);
        v1 = seed;
        seed = lfsr(seed);
        v2 = seed;
        wr(ADDR_COUNT_LO, v1);
        wr(ADDR_COUNT_HI, v2);
        tick(3);
        ro(ADDR_COUNT_LO, v1);
        ro(ADDR_COUNT_HI, v2);
        for (ps = 0; ps < 4; ps++) begin
            wr(ADDR_CONTROL, {2'h0, ps[1:0], 1'b0, ps == 2, 2'h1});
            wr(ADDR_COUNT_LO, 8'h00);
            wr(ADDR_COUNT_HI, 8'h00);
            tick(8);
            ro(ADDR_COUNT_LO, 8'h08 >> ps);
        end
        i_sbtc_ext_src.burst(3, 110);
        cyc(4);
        ro(ADDR_COUNT_LO, 8'h01);
        wr(ADDR_CONTROL, 8'h01);
        wr(ADDR_COUNT_LO, 8'hFF);
        wr(ADDR_COUNT_HI, 8'hFF);
        tick(1);
        cyc(2);
        chk({1'b0, overflow_irq_o}, 2'h1);
        ro(ADDR_COUNT_HI, 8'h00);
        ro(ADDR_STATUS, 8'h01);
        tick(2);
        chk({1'b0, overflow_irq_o}, 2'h1);
        wr(ADDR_STATUS, 8'h01);
        cyc(3);
        chk({1'b0, overflow_irq_o}, 2'h0);
        @(posedge clk_sys_i);
        cc_trigger_i <= 1'b1;
        @(posedge clk_sys_i);
        cc_trigger_i <= 1'b0;
        cyc(2);
        ro(ADDR_COUNT_LO, 8'h00);
        wr(ADDR_CONTROL, 8'h03);
        wr(ADDR_COUNT_LO, 8'h00);
        i_sbtc_ext_src.burst(5, 110);
        cyc(6);
        ro(ADDR_COUNT_LO, 8'h05);
        wr(ADDR_CONTROL, 8'h07);
        wr(ADDR_COUNT_LO, 8'h00);
        i_sbtc_ext_src.burst(5, 157);
        cyc(8);
        ro(ADDR_COUNT_LO, 8'h05);
        wr(ADDR_PINDIR, 8'h00);
        repeat (3) begin
            seed = lfsr(seed);
            port_out_i <= seed[1:0];
            cyc(3);
            chk(osc_pin_o, seed[1:0]);
        end
        chk(osc_pin_oe_o, 2'h3);
        wr(ADDR_CONTROL, 8'h08);
        cyc(2);
        chk(osc_pin_oe_o, 2'h0);
        chk({1'b0, osc_run_o}, 2'h1);
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_PINDIR, 8'h01);
        s_axi_wstrb <= 4'hE;
        wr(ADDR_PINDIR, 8'h03);
        s_axi_wstrb <= 4'hF;
        cyc(2);
        chk(osc_pin_oe_o, 2'h2);
        chk({1'b0, osc_run_o}, 2'h0);
        cyc(3);
        report_and_stop();
    end
endmodule : tb_top
